//--- hdl/arce_regs.vh
// Task-file offsets, command codes, field positions and timing counts for the read command engine
`ifndef ARCE_REGS_VH
`define ARCE_REGS_VH
// Task-file register offsets (4-bit port address)
`define ARCE_A_DATA 4'h0
`define ARCE_A_FEAT 4'h1
`define ARCE_A_SCNT 4'h2
`define ARCE_A_LBAL 4'h3
`define ARCE_A_LBAM 4'h4
`define ARCE_A_LBAH 4'h5
`define ARCE_A_DEVH 4'h6
`define ARCE_A_CMD 4'h7
`define ARCE_A_DCTL 4'h8
`define ARCE_A_IRQS 4'h9
`define ARCE_A_IRQM 4'hA
`define ARCE_A_NMAX 4'hB
// Command codes
`define ARCE_C_NMAX 8'hF8
`define ARCE_C_NMAXX 8'h27
`define ARCE_C_RD 8'h20
`define ARCE_C_RDX 8'h24
// Field positions
`define ARCE_HOB_BIT 7
`define ARCE_LBA_BIT 6
`define ARCE_ST_BSY 7
`define ARCE_ST_DRDY 6
`define ARCE_ST_DRQ 3
`define ARCE_ST_ERR 0
// Error register value for an uncorrectable data error, abort
`define ARCE_ER_UNC 8'h40
`define ARCE_ER_ABRT 8'h04
// Interrupt status bits
`define ARCE_IRQ_DRQ 0
`define ARCE_IRQ_DONE 1
`define ARCE_IRQ_ERR 2
// Sector geometry and timing
`define ARCE_SECT_WORDS 256
`define ARCE_LOAD_NS 1000
`define ARCE_CLK_NS 100
`define ARCE_LOAD_CYC ((`ARCE_LOAD_NS + `ARCE_CLK_NS - 1) / `ARCE_CLK_NS)
// Reset value of the native maximum address
`define ARCE_NMAX_RST 48'h0000_00FF_FFFF
`endif

//--- hdl/arce_sector_buf.v
// Sector buffer: one sector of 16-bit words, filled by the loader, drained by host data reads
`timescale 1ns/10ps
module arce_sector_buf #(
    parameter WORDS = 256,
    parameter AW = 8
) (
    // Clock
    input wire clock,
    // Fill side
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [15:0] wr_data,
    // Drain side
    input wire [AW-1:0] rd_addr,
    output reg [15:0] rd_data
);
    reg [15:0] mem [0:WORDS-1];

    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // arce_sector_buf

//--- hdl/arce_engine.v
// ATA read command engine: native max address queries and PIO read sectors with a sector buffer
//
// Functional notes
// - Command F8h returns native maximum address, no data phase, ignoring protected area.
// - 28-bit result sits in device/head nibble, LBA high, mid and low.
// - Command 27h returns the native maximum address in 48-bit form.
// - 48-bit result held in three 16-bit LBA high, mid, low registers.
// - High-order-byte bit of device control selects which byte reads back.
// - HOB=1 gives bits 47:24, HOB=0 gives 23:0; status and device same.
// - Command 20h reads 1 to 256 sectors; count zero means 256.
// - 28-bit read starts at sector addressed by LBA registers and head nibble.
// - Per sector: busy, load buffer, data request and busy clear in one cycle, interrupt, in order.
// - 28-bit read error stops at failing sector, reports its address, keeps data.
// - Command 24h reads 1 to 65536 sectors; count zero means 65536.
// - Successful 48-bit read leaves last sector LBA in the registers.
// - 48-bit read error ends at failing sector, reports its LBA, keeps data.
`timescale 1ns/10ps
`include "arce_regs.vh"
module arce_engine #(
    parameter LOAD_CYC = `ARCE_LOAD_CYC,
    parameter [47:0] NMAX_RST = `ARCE_NMAX_RST
) (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Task-file port
    input wire [3:0] tf_addr,
    input wire [15:0] tf_wdata,
    input wire tf_wr,
    input wire tf_rd,
    output reg [15:0] tf_rdata_ff,
    // Media side: sector fetch request and returned words
    output reg media_req_ff,
    output reg [47:0] media_lba_ff,
    input wire media_valid,
    input wire [15:0] media_data,
    input wire media_err,
    // Interrupt
    output reg irq_ff
);
    localparam S_IDLE = 3'h0;
    localparam S_LOAD = 3'h1;
    localparam S_XFER = 3'h2;
    localparam S_WAIT = 3'h3;

    reg [2:0] state_ff, nxt_state;
    reg [7:0] cmd_ff;
    reg [7:0] devh_ff;
    reg [47:0] lba_ff;
    reg [15:0] scnt_ff;
    // Spare top bit holds the 65536 of a zero 48-bit count
    reg [16:0] left_ff;
    reg hob_ff;
    reg bsy_ff, drq_ff, err_ff;
    reg [7:0] error_ff;
    reg [2:0] ists_ff, imsk_ff;
    reg [47:0] nmax_ff;
    reg [7:0] widx_ff;
    reg [7:0] ridx_ff;
    reg [7:0] ldcnt_ff;
    reg ext_ff;
    wire [15:0] buf_rd;

    // Each sector count or LBA task-file write shifts the old low byte into the high byte
    function [15:0] push_byte;
        input [15:0] old;
        input [7:0] b;
        begin
            push_byte = {old[7:0], b};
        end
    endfunction

    // Pick HOB byte of a 16-bit register
    function [7:0] sel_byte;
        input [15:0] v;
        input hob;
        begin
            sel_byte = hob ? v[15:8] : v[7:0];
        end
    endfunction

    // Ready simply follows not-busy; there is no separate spin-up state
    wire [7:0] status = {bsy_ff, ~bsy_ff, 1'b0, 1'b0, drq_ff, 2'b00, err_ff};
    wire data_rd = tf_rd && tf_addr == `ARCE_A_DATA && drq_ff;
    wire last_word = ridx_ff == 8'hFF;
    // Commands written while busy or requesting data are dropped, not queued
    wire cmd_wr = tf_wr && tf_addr == `ARCE_A_CMD && !bsy_ff && !drq_ff;
    // Data-request event taken with DRQ itself, so flag and status agree
    wire ev_drq = state_ff == S_XFER;
    wire ev_done = state_ff == S_WAIT && data_rd && last_word && left_ff == 17'h1;
    wire ev_err = state_ff == S_LOAD && media_err;
    wire [2:0] ev_set = {ev_err, ev_done, ev_drq};

    // Read address runs one ahead on a data read so back-to-back reads stream
    arce_sector_buf #(.WORDS(`ARCE_SECT_WORDS), .AW(8)) u_buf (
        .clock(clock),
        .wr_en(state_ff == S_LOAD && media_valid && !media_err),
        .wr_addr(widx_ff),
        .wr_data(media_data),
        .rd_addr(data_rd ? ridx_ff + 8'h01 : ridx_ff),
        .rd_data(buf_rd)
    );

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (cmd_wr && (tf_wdata[7:0] == `ARCE_C_RD || tf_wdata[7:0] == `ARCE_C_RDX)) begin
                    nxt_state = S_LOAD;
                end
            end
            S_LOAD: begin
                if (media_err) begin
                    nxt_state = S_IDLE;
                end else if (media_valid && widx_ff == 8'hFF && ldcnt_ff >= LOAD_CYC[7:0]) begin
                    nxt_state = S_XFER;
                end
            end
            S_XFER: nxt_state = S_WAIT;
            S_WAIT: begin
                if (data_rd && last_word) begin
                    nxt_state = (left_ff == 17'h1) ? S_IDLE : S_LOAD;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= S_IDLE;
            cmd_ff <= 8'h00;
            devh_ff <= 8'hE0;
            lba_ff <= 48'h0;
            scnt_ff <= 16'h0;
            left_ff <= 17'h0;
            hob_ff <= 1'b0;
            bsy_ff <= 1'b0;
            drq_ff <= 1'b0;
            err_ff <= 1'b0;
            error_ff <= 8'h00;
            ists_ff <= 3'h0;
            imsk_ff <= 3'h0;
            nmax_ff <= NMAX_RST;
            widx_ff <= 8'h00;
            ridx_ff <= 8'h00;
            ldcnt_ff <= 8'h00;
            ext_ff <= 1'b0;
            media_req_ff <= 1'b0;
            media_lba_ff <= 48'h0;
            tf_rdata_ff <= 16'h0;
            irq_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // Set wins over a write-one clear in the same cycle
            ists_ff <= (ists_ff & ~((tf_wr && tf_addr == `ARCE_A_IRQS) ? tf_wdata[2:0] : 3'h0)) | ev_set;
            // From registered status only, so it rises after DRQ set and busy cleared
            irq_ff <= |(ists_ff & imsk_ff);
            if (tf_wr) begin
                case (tf_addr)
                    `ARCE_A_DCTL: hob_ff <= tf_wdata[`ARCE_HOB_BIT];
                    `ARCE_A_IRQM: imsk_ff <= tf_wdata[2:0];
                    `ARCE_A_NMAX: nmax_ff <= {nmax_ff[31:0], tf_wdata};
                    default: ;
                endcase
                // Command-block writes are locked out while the command runs
                if (!bsy_ff && !drq_ff) begin
                    case (tf_addr)
                        `ARCE_A_SCNT: scnt_ff <= push_byte(scnt_ff, tf_wdata[7:0]);
                        `ARCE_A_LBAL: {lba_ff[31:24], lba_ff[7:0]} <=
                            push_byte({lba_ff[31:24], lba_ff[7:0]}, tf_wdata[7:0]);
                        `ARCE_A_LBAM: {lba_ff[39:32], lba_ff[15:8]} <=
                            push_byte({lba_ff[39:32], lba_ff[15:8]}, tf_wdata[7:0]);
                        `ARCE_A_LBAH: {lba_ff[47:40], lba_ff[23:16]} <=
                            push_byte({lba_ff[47:40], lba_ff[23:16]}, tf_wdata[7:0]);
                        `ARCE_A_DEVH: devh_ff <= tf_wdata[7:0];
                        default: ;
                    endcase
                end
            end
            if (cmd_wr) begin
                cmd_ff <= tf_wdata[7:0];
                err_ff <= 1'b0;
                error_ff <= 8'h00;
                // Features, count and unused fields are not checked
                case (tf_wdata[7:0])
                    `ARCE_C_NMAX: begin
                        // Immediate answer, no data phase
                        {devh_ff[3:0], lba_ff[23:0]} <= nmax_ff[27:0];
                        lba_ff[47:24] <= 24'h0;
                    end
                    `ARCE_C_NMAXX: lba_ff <= nmax_ff;
                    `ARCE_C_RD: begin
                        // Zero count means the full 256
                        left_ff <= (scnt_ff[7:0] == 8'h00) ? 17'h100 : {9'h0, scnt_ff[7:0]};
                        // Start at device/head nibble plus LBA registers
                        media_lba_ff <= {20'h0, devh_ff[3:0], lba_ff[23:0]};
                        ext_ff <= 1'b0;
                        bsy_ff <= 1'b1;
                    end
                    `ARCE_C_RDX: begin
                        left_ff <= (scnt_ff == 16'h0) ? 17'h10000 : {1'b0, scnt_ff};
                        media_lba_ff <= lba_ff;
                        ext_ff <= 1'b1;
                        bsy_ff <= 1'b1;
                    end
                    default: begin
                        err_ff <= 1'b1;
                        error_ff <= `ARCE_ER_ABRT;
                    end
                endcase
            end
            case (state_ff)
                S_IDLE: begin
                    // Fill pointers parked at zero between commands
                    widx_ff <= 8'h00;
                    ldcnt_ff <= 8'h00;
                    media_req_ff <= nxt_state == S_LOAD;
                end
                S_LOAD: begin
                    // Busy held while the sector fills
                    bsy_ff <= 1'b1;
                    // Saturates at 255; the compare uses only the low 8 bits of LOAD_CYC
                    if (ldcnt_ff != 8'hFF) begin
                        ldcnt_ff <= ldcnt_ff + 8'h01;
                    end
                    if (media_valid && widx_ff != 8'hFF) begin
                        widx_ff <= widx_ff + 8'h01;
                    end
                    if (media_valid && widx_ff == 8'hFF) begin
                        media_req_ff <= 1'b0;
                    end
                    if (media_err) begin
                        // Stop at failing sector, report its address, keep buffer
                        bsy_ff <= 1'b0;
                        err_ff <= 1'b1;
                        error_ff <= `ARCE_ER_UNC;
                        media_req_ff <= 1'b0;
                        if (ext_ff) begin
                            lba_ff <= media_lba_ff;
                        end else begin
                            {devh_ff[3:0], lba_ff[23:0]} <= media_lba_ff[27:0];
                        end
                    end
                end
                S_XFER: begin
                    // Data request set and busy dropped in the same cycle; interrupt rises one cycle later
                    drq_ff <= 1'b1;
                    bsy_ff <= 1'b0;
                    ridx_ff <= 8'h00;
                end
                S_WAIT: begin
                    if (data_rd) begin
                        ridx_ff <= ridx_ff + 8'h01;
                    end
                    // One full sector drained per request
                    if (data_rd && last_word) begin
                        drq_ff <= 1'b0;
                        left_ff <= left_ff - 17'h1;
                        if (left_ff == 17'h1) begin
                            // Report last sector read
                            if (ext_ff) begin
                                lba_ff <= media_lba_ff;
                            end else begin
                                {devh_ff[3:0], lba_ff[23:0]} <= media_lba_ff[27:0];
                            end
                        end else begin
                            bsy_ff <= 1'b1;
                            media_lba_ff <= media_lba_ff + 48'h1;
                            media_req_ff <= 1'b1;
                            widx_ff <= 8'h00;
                            ldcnt_ff <= 8'h00;
                        end
                    end
                end
                default: ;
            endcase
            if (tf_rd) begin
                case (tf_addr)
                    `ARCE_A_DATA: tf_rdata_ff <= drq_ff ? buf_rd : 16'h0;
                    `ARCE_A_FEAT: tf_rdata_ff <= {8'h0, error_ff};
                    `ARCE_A_SCNT: tf_rdata_ff <= {8'h0, sel_byte(scnt_ff, hob_ff)};
                    `ARCE_A_LBAL: tf_rdata_ff <= {8'h0, sel_byte({lba_ff[31:24], lba_ff[7:0]}, hob_ff)};
                    `ARCE_A_LBAM: tf_rdata_ff <= {8'h0, sel_byte({lba_ff[39:32], lba_ff[15:8]}, hob_ff)};
                    `ARCE_A_LBAH: tf_rdata_ff <= {8'h0, sel_byte({lba_ff[47:40], lba_ff[23:16]}, hob_ff)};
                    `ARCE_A_DEVH: tf_rdata_ff <= {8'h0, devh_ff};
                    `ARCE_A_CMD: tf_rdata_ff <= {8'h0, status};
                    `ARCE_A_DCTL: tf_rdata_ff <= {8'h0, status};
                    `ARCE_A_IRQS: tf_rdata_ff <= {13'h0, ists_ff};
                    `ARCE_A_IRQM: tf_rdata_ff <= {13'h0, imsk_ff};
                    `ARCE_A_NMAX: tf_rdata_ff <= nmax_ff[15:0];
                    default: tf_rdata_ff <= 16'h0;
                endcase
            end else begin
                tf_rdata_ff <= 16'h0;
            end
        end
    end
endmodule // arce_engine

//--- sim/arce_media_model.sv
// Media model: serves one sector of words for each fetch request
`timescale 1ns/10ps
module arce_media_model (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Engine side
    input wire media_req_ff,
    input wire [47:0] media_lba_ff,
    output reg media_valid,
    output reg [15:0] media_data,
    output reg media_err,
    // Failing sector and stall mode
    input wire [47:0] err_lba,
    input wire slow
);
    reg [8:0] idx_ff;
    reg served_ff;
    reg ph_ff;
    reg [47:0] slba_ff;
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            idx_ff <= 9'h000;
            served_ff <= 1'b0;
            ph_ff <= 1'b0;
            slba_ff <= 48'h0;
            media_valid <= 1'b0;
            media_data <= 16'h0000;
            media_err <= 1'b0;
        end else begin
            media_valid <= 1'b0;
            media_err <= 1'b0;
            // Idle words never repeat the last one
            media_data <= ~media_data;
            ph_ff <= ~ph_ff;
            if (!media_req_ff || media_lba_ff != slba_ff) begin
                served_ff <= 1'b0;
                idx_ff <= 9'h000;
                slba_ff <= media_lba_ff;
            end else if (!served_ff && (!slow || ph_ff)) begin
                if (media_lba_ff == err_lba) begin
                    media_err <= 1'b1;
                    served_ff <= 1'b1;
                end else begin
                    media_valid <= 1'b1;
                    media_data <= {media_lba_ff[7:0], idx_ff[7:0]};
                    idx_ff <= idx_ff + 9'h001;
                    served_ff <= (idx_ff == 9'h0FF);
                end
            end
        end
    end
endmodule // arce_media_model

//--- sim/arce_engine_chk.sv
// Port-level assertions for the read command engine
`timescale 1ns/10ps
`include "arce_regs.vh"
module arce_engine_chk (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Task-file port
    input wire [3:0] tf_addr,
    input wire [15:0] tf_wdata,
    input wire tf_wr,
    input wire tf_rd,
    input wire [15:0] tf_rdata_ff,
    // Media and interrupt
    input wire media_req_ff,
    input wire [47:0] media_lba_ff,
    input wire media_valid,
    input wire media_err,
    input wire irq_ff
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire cmd_wr = tf_wr && tf_addr == `ARCE_A_CMD && !media_req_ff;
    wire [7:0] cmd = tf_wdata[7:0];
    a_rdata_one_cycle: assert property (!$past(tf_rd) |-> tf_rdata_ff == 16'h0000)
        else $error("read data outside its cycle");
    a_read_starts: assert property (cmd_wr && (cmd == `ARCE_C_RD || cmd == `ARCE_C_RDX) |-> ##2 media_req_ff)
        else $error("read did not fetch");
    a_nmax_no_fetch: assert property (cmd_wr && (cmd == `ARCE_C_NMAX || cmd == `ARCE_C_NMAXX) |=> !media_req_ff [*4])
        else $error("native max fetched media");
    a_lba_held: assert property (media_valid |=> $stable(media_lba_ff))
        else $error("fetch address moved in sector");
    a_err_stops: assert property (media_err |-> ##6 !media_req_ff [*8])
        else $error("fetch went on after error");
    a_mask_clears: assert property (tf_wr && tf_addr == `ARCE_A_IRQM && tf_wdata[2:0] == 3'h0 |-> ##[1:2] !irq_ff)
        else $error("masked interrupt stayed");
    a_fetch_bounded: assert property ($rose(media_req_ff) |-> ##[1:800] !media_req_ff)
        else $error("fetch never ended");
    a_irq_after_load: assert property (media_valid |=> !$rose(irq_ff))
        else $error("interrupt during load");
endmodule // arce_engine_chk
bind arce_engine arce_engine_chk u_arce_engine_chk (.clock(clock), .arst_n(arst_n), .tf_addr(tf_addr),
    .tf_wdata(tf_wdata), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_rdata_ff(tf_rdata_ff), .media_req_ff(media_req_ff),
    .media_lba_ff(media_lba_ff), .media_valid(media_valid), .media_err(media_err), .irq_ff(irq_ff));

//--- sim/arce_engine_tb.sv
// Self-checking bench for the read command engine
`timescale 1ns/10ps
`include "arce_regs.vh"
module arce_engine_tb;
    reg clock = 1'b0;
    reg arst_n = 1'b0;
    reg [3:0] tf_addr = 4'h0;
    reg [15:0] tf_wdata = 16'h0000;
    reg tf_wr = 1'b0;
    reg tf_rd = 1'b0;
    reg [47:0] err_lba = 48'hFFFF_FFFF_FFFF;
    reg slow = 1'b0;
    wire [15:0] tf_rdata_ff;
    wire media_req_ff;
    wire [47:0] media_lba_ff;
    wire media_valid;
    wire [15:0] media_data;
    wire media_err;
    wire irq_ff;
    integer error_cnt = 0;
    integer n_compared = 0;
    integer h;
    reg [47:0] v;
    always #50 clock = ~clock;
    // Short load time keeps the run brief
    arce_engine #(.LOAD_CYC(2)) u_arce_engine (.clock(clock), .arst_n(arst_n), .tf_addr(tf_addr),
        .tf_wdata(tf_wdata), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_rdata_ff(tf_rdata_ff), .media_req_ff(media_req_ff),
        .media_lba_ff(media_lba_ff), .media_valid(media_valid), .media_data(media_data), .media_err(media_err),
        .irq_ff(irq_ff));
    arce_media_model u_arce_media_model (.clock(clock), .arst_n(arst_n), .media_req_ff(media_req_ff),
        .media_lba_ff(media_lba_ff), .media_valid(media_valid), .media_data(media_data), .media_err(media_err),
        .err_lba(err_lba), .slow(slow));
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge clock);
            tf_addr <= a;
            tf_wdata <= d;
            tf_wr <= 1'b1;
            @(posedge clock);
            tf_wr <= 1'b0;
        end
    endtask
    task rdc(input [3:0] a, input [15:0] m, input [15:0] e);
        begin
            @(posedge clock);
            tf_addr <= a;
            tf_rd <= 1'b1;
            @(posedge clock);
            tf_rd <= 1'b0;
            #1;
            chk(tf_rdata_ff & m, e);
        end
    endtask
    task wait_irq;
        integer n;
        begin
            for (n = 0; n < 2000 && irq_ff !== 1'b1; n = n + 1)
                @(negedge clock);
            chk({15'h0000, irq_ff}, 16'h0001);
        end
    endtask
    task rst;
        begin
            arst_n <= 1'b0;
            repeat (12) @(posedge clock);
            arst_n <= 1'b1;
        end
    endtask
    task set_tf(input [47:0] a, input [15:0] c);
        begin
            wr(`ARCE_A_SCNT, {8'h00, c[15:8]});
            wr(`ARCE_A_SCNT, {8'h00, c[7:0]});
            wr(`ARCE_A_LBAL, {8'h00, a[31:24]});
            wr(`ARCE_A_LBAL, {8'h00, a[7:0]});
            wr(`ARCE_A_LBAM, {8'h00, a[39:32]});
            wr(`ARCE_A_LBAM, {8'h00, a[15:8]});
            wr(`ARCE_A_LBAH, {8'h00, a[47:40]});
            wr(`ARCE_A_LBAH, {8'h00, a[23:16]});
            wr(`ARCE_A_DEVH, {12'h00E, a[27:24]});
        end
    endtask
    // Reads nrun sectors; full says the count ends there, err_at the failing sector
    task run_read(input [7:0] cmd, input [47:0] lba, input [15:0] cnt, input integer nrun, input integer err_at,
        input full);
        integer s;
        integer i;
        reg [47:0] cur;
        begin
            wr(`ARCE_A_IRQM, 16'h0000);
            // Stale done or error bits would raise the interrupt before the first sector
            wr(`ARCE_A_IRQS, 16'h0007);
            wr(`ARCE_A_IRQM, 16'h0007);
            set_tf(lba, cnt);
            wr(`ARCE_A_CMD, {8'h00, cmd});
            for (s = 0; s < nrun; s = s + 1) begin
                cur = lba + s;
                wait_irq;
                if (s == err_at) begin
                    rdc(`ARCE_A_IRQS, 16'h0004, 16'h0004);
                    rdc(`ARCE_A_CMD, 16'h0089, 16'h0001);
                    rdc(`ARCE_A_FEAT, 16'h00FF, {8'h00, `ARCE_ER_UNC});
                    rdc(`ARCE_A_LBAL, 16'h00FF, {8'h00, cur[7:0]});
                    s = nrun + 1;
                end else begin
                    rdc(`ARCE_A_IRQS, 16'h0001, 16'h0001);
                    rdc(`ARCE_A_CMD, 16'h0088, 16'h0008);
                    chk(media_lba_ff[31:16], cur[31:16]);
                    wr(`ARCE_A_IRQS, 16'h0007);
                    for (i = 0; i < `ARCE_SECT_WORDS; i = i + 1)
                        rdc(`ARCE_A_DATA, 16'hFFFF, {cur[7:0], i[7:0]});
                end
            end
            if (s == nrun) begin
                wait_irq;
                rdc(`ARCE_A_IRQS, 16'h0003, full ? 16'h0002 : 16'h0001);
                if (full)
                    rdc(`ARCE_A_LBAM, 16'h00FF, {8'h00, cur[15:8]});
                if (full)
                    rdc(`ARCE_A_LBAL, 16'h00FF, {8'h00, cur[7:0]});
            end
        end
    endtask
    task t_reset;
        begin
            rdc(`ARCE_A_CMD, 16'hFFFF, 16'h0040);
            rdc(`ARCE_A_IRQS, 16'hFFFF, 16'h0000);
            rdc(4'hC, 16'hFFFF, 16'h0000);
            rdc(`ARCE_A_DATA, 16'hFFFF, 16'h0000);
            $display("t_reset end");
        end
    endtask
    task t_nmax;
        begin
            v = `ARCE_NMAX_RST;
            wr(`ARCE_A_FEAT, 16'h00A5);
            wr(`ARCE_A_DEVH, 16'h00E0);
            wr(`ARCE_A_CMD, {8'h00, `ARCE_C_NMAX});
            rdc(`ARCE_A_LBAH, 16'h00FF, {8'h00, v[23:16]});
            rdc(`ARCE_A_LBAM, 16'h00FF, {8'h00, v[15:8]});
            rdc(`ARCE_A_LBAL, 16'h00FF, {8'h00, v[7:0]});
            rdc(`ARCE_A_DEVH, 16'h000F, {12'h000, v[27:24]});
            wr(`ARCE_A_NMAX, 16'h1234);
            wr(`ARCE_A_NMAX, 16'h5678);
            wr(`ARCE_A_NMAX, 16'h9ABC);
            wr(`ARCE_A_CMD, {8'h00, `ARCE_C_NMAXX});
            for (h = 0; h < 2; h = h + 1) begin
                v = h ? 48'h1234_5678_9ABC >> 24 : 48'h1234_5678_9ABC;
                wr(`ARCE_A_DCTL, h ? 16'h0080 : 16'h0000);
                rdc(`ARCE_A_LBAH, 16'h00FF, {8'h00, v[23:16]});
                rdc(`ARCE_A_LBAM, 16'h00FF, {8'h00, v[15:8]});
                rdc(`ARCE_A_LBAL, 16'h00FF, {8'h00, v[7:0]});
                rdc(`ARCE_A_CMD, 16'h0089, 16'h0000);
                rdc(`ARCE_A_DEVH, 16'h00F0, 16'h00E0);
            end
            wr(`ARCE_A_DCTL, 16'h0000);
            $display("t_nmax end");
        end
    endtask
    task t_read;
        begin
            run_read(`ARCE_C_RD, 48'h0000_0100_00FF, 16'h0002, 2, -1, 1'b1);
            slow <= 1'b1;
            run_read(`ARCE_C_RDX, 48'h0012_3456_78FE, 16'h0002, 2, -1, 1'b1);
            slow <= 1'b0;
            wr(`ARCE_A_DCTL, 16'h0080);
            rdc(`ARCE_A_LBAL, 16'h00FF, 16'h0034);
            rdc(`ARCE_A_LBAM, 16'h00FF, 16'h0012);
            wr(`ARCE_A_DCTL, 16'h0000);
            $display("t_read end");
        end
    endtask
    task t_count0;
        begin
            run_read(`ARCE_C_RD, 48'h10, 16'h0000, 2, -1, 1'b0);
            rst;
            run_read(`ARCE_C_RDX, 48'h20, 16'h0000, 2, -1, 1'b0);
            rst;
            $display("t_count0 end");
        end
    endtask
    task t_error;
        begin
            err_lba <= 48'h41;
            run_read(`ARCE_C_RD, 48'h40, 16'h0003, 2, 1, 1'b0);
            run_read(`ARCE_C_RDX, 48'h40, 16'h0003, 2, 1, 1'b0);
            wr(`ARCE_A_CMD, 16'h00EE);
            rdc(`ARCE_A_FEAT, 16'h00FF, {8'h00, `ARCE_ER_ABRT});
            $display("t_error end");
        end
    endtask
    task results;
        begin
            $display("compared %0d mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt = error_cnt + 1;
        results;
    end
    initial begin
        rst;
        t_reset;
        t_nmax;
        t_read;
        t_count0;
        t_error;
        results;
    end
endmodule // arce_engine_tb
